// *** hdl/rcw_core.sv ***
// rcw_core: reset-cause register, reset/wake sequencer, watchdog and
// idle/sleep control.
// assumes a core that reports its pc and one-cycle instruction strobes.
//
// Operation
// - monitor on, no timer: leave reset at once
// - no monitor, no clock: freeze at vector
// - all cause flags software readable and writable
// - power-on: pc 0, only power-on flag
// - pin reset running: pin flag, clear software, timeout, idle and sleep flags
// - software reset: software flag, clear pin, timeout, idle and sleep flags
// - pin reset sleeping: pin and sleep flags
// - pin reset idle: pin and idle flags
// - watchdog overflow running: reset, timeout flag
// - watchdog in sleep: wake at pc+2
// - interrupt wakes sleep: vector, sleep flag
// - watchdog counts on its own rc clock
// - fuse bit one enables the watchdog
// - fuse zero: soft enable bit decides
// - power-save operand selects idle or sleep
// - idle gates cpu clock, peripherals run
// - idle keeps rc clock when monitor enabled
// - idle exits on interrupt, reset, watchdog
// - interrupt wake from idle sets idle flag
// - idle wake resumes with no delay
// - watchdog in idle: wake, both flags
// - trap and illegal op own flags
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/100ps
module rcw_core #(
  parameter int unsigned POWER_UP_TIMER_CYCLES = rcw_pkg::POWER_UP_TIMER_MS * rcw_pkg::CLK_KHZ
) (
  input  wire logic                     mclk_i,
  input  wire logic                     rst_i,
  input  wire rcw_pkg::rcw_bus_req_type bus_i,
  output logic [31:0]                   rdata_o,
  input  wire logic                     master_clear_pin_n_i,
  input  wire logic                     sys_clk_ok_i,
  input  wire logic                     low_power_rc_osc_clk_i,
  input  wire logic                     wdt_fuse_en_i,
  input  wire logic                     clock_fail_monitor_en_i,
  input  wire logic                     power_up_timer_en_i,
  input  wire logic                     sw_reset_i,
  input  wire logic                     trap_reset_i,
  input  wire logic                     illegal_op_i,
  input  wire logic                     watchdog_clear_instr_i,
  input  wire logic                     power_save_instr_i,
  input  wire logic                     power_save_instr_sleep_i,
  input  wire logic                     irq_wake_i,
  input  wire logic [23:0]              irq_vector_i,
  input  wire logic [23:0]              pc_i,
  output logic                          core_reset_o,
  output logic                          cpu_clk_en_o,
  output logic                          periph_clk_en_o,
  output logic                          low_power_rc_osc_run_o,
  output logic                          pc_load_o,
  output logic [23:0]                   pc_target_o,
  output logic                          wdt_running_o
);
  import rcw_pkg::*;

  logic [5:0]           sync1_q;
  logic [5:0]           sync2_q;
  logic [1:0]           sync_ok_q;
  logic                 master_clear_pin_prev_q;
  logic                 low_power_rc_osc_prev_q;
  logic                 fuse_wdt_q;
  logic                 fuse_clock_fail_monitor_q;
  logic [15:0]          cause_q;
  logic [15:0]          cause_d;
  rcw_state_type        state_q;
  rcw_state_type        state_d;
  logic [31:0]          power_up_timer_cnt_q;
  logic [WDT_CNT_W-1:0] wdt_cnt_q;
  logic [23:0]          save_pc_q;
  logic [23:0]          target_d;
  logic                 load_d;
  logic                 master_clear_pin_n_s;
  logic                 clk_ok_s;
  logic                 low_power_rc_osc_s;
  logic                 master_clear_pin_fall;
  logic                 low_power_rc_osc_tick;
  logic                 wdt_en;
  logic                 wdt_ovf;
  logic                 wdt_clr;
  logic                 power_up_timer_done;
  logic                 wr_cause;

  // clear bits then set bits of the cause register
  function automatic logic [15:0] upd(input logic [15:0] c,
                                      input logic [15:0] set_m,
                                      input logic [15:0] clr_m);
    upd = (c & ~clr_m) | set_m;
  endfunction

  function automatic logic [15:0] bm(input int pos);
    bm = 16'h0001 << pos;
  endfunction

  // start-up may proceed once a clock runs or the monitor takes over
  function automatic logic can_start(input logic clk_ok,
                                     input logic clock_fail_monitor);
    can_start = clk_ok | clock_fail_monitor;
  endfunction

  // two-flop synchronisers for pins and the rc clock
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sync1_q   <= SYNC_RST;
      sync2_q   <= SYNC_RST;
      sync_ok_q <= 2'h0;
    end else begin
      sync1_q   <= {power_up_timer_en_i, clock_fail_monitor_en_i, wdt_fuse_en_i,
                    low_power_rc_osc_clk_i, sys_clk_ok_i, master_clear_pin_n_i};
      sync2_q   <= sync1_q;
      sync_ok_q <= {sync_ok_q[0], 1'b1};
    end
  end

  assign master_clear_pin_n_s = sync2_q[0];
  assign clk_ok_s = sync2_q[1];
  assign low_power_rc_osc_s   = sync2_q[2];

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      master_clear_pin_prev_q <= 1'b1;
      low_power_rc_osc_prev_q <= 1'b0;
    end else begin
      master_clear_pin_prev_q <= master_clear_pin_n_s;
      low_power_rc_osc_prev_q <= low_power_rc_osc_s;
    end
  end

  assign master_clear_pin_fall = master_clear_pin_prev_q & ~master_clear_pin_n_s;
  assign low_power_rc_osc_tick = low_power_rc_osc_s & ~low_power_rc_osc_prev_q;

  // fuses caught while the sequencer sits in reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fuse_wdt_q  <= 1'b1;
      fuse_clock_fail_monitor_q <= 1'b0;
    end else if (state_q == ST_RESET) begin
      fuse_wdt_q  <= sync2_q[3];
      fuse_clock_fail_monitor_q <= sync2_q[4];
    end
  end

  // power-up timer
  always_ff @(posedge mclk_i) begin
    if (rst_i || state_q != ST_POWER_UP_TIMER) begin
      power_up_timer_cnt_q <= 32'h0;
    end else begin
      power_up_timer_cnt_q <= power_up_timer_cnt_q + 32'h1;
    end
  end

  assign power_up_timer_done = (power_up_timer_cnt_q == 32'(POWER_UP_TIMER_CYCLES - 1));

  // watchdog enable and counter on rc clock ticks
  assign wdt_en = fuse_wdt_q | cause_q[BIT_WATCHDOG_SOFT_ENABLE];
  assign wdt_clr = watchdog_clear_instr_i & (state_q == ST_RUN);
  assign wdt_ovf = wdt_en & low_power_rc_osc_tick &
                   (wdt_cnt_q == WDT_TICKS - 16'h1)
                   & (state_q == ST_RUN || state_q == ST_IDLE ||
                      state_q == ST_SLEEP);

  always_ff @(posedge mclk_i) begin
    if (rst_i || !wdt_en || wdt_clr || wdt_ovf) begin
      wdt_cnt_q <= '0;
    end else if (state_q == ST_RESET || state_q == ST_POWER_UP_TIMER ||
                 state_q == ST_FROZEN) begin
      wdt_cnt_q <= '0;
    end else if (low_power_rc_osc_tick) begin
      wdt_cnt_q <= wdt_cnt_q + 16'h1;
    end
  end

  assign wr_cause = bus_i.wr && (bus_i.addr == REG_RESET_CAUSE);

  // sequencer and cause flags; hardware events override a write
  always_comb begin
    cause_d  = cause_q;
    state_d  = state_q;
    load_d   = 1'b0;
    target_d = pc_target_o;
    if (wr_cause) begin
      cause_d = bus_i.wdata[15:0] & CAUSE_WMASK;
    end
    if (master_clear_pin_fall) begin
      if (state_q == ST_SLEEP) begin
        cause_d = upd(cause_d, bm(BIT_EXTERNAL_PIN_RESET_FLAG) | bm(BIT_SLEEP),
                      bm(BIT_WATCHDOG_TIMEOUT_FLAG) | bm(BIT_IDLE));
      end else if (state_q == ST_IDLE) begin
        cause_d = upd(cause_d, bm(BIT_EXTERNAL_PIN_RESET_FLAG) | bm(BIT_IDLE),
                      bm(BIT_WATCHDOG_TIMEOUT_FLAG) | bm(BIT_SLEEP));
      end else begin
        cause_d = upd(cause_d, bm(BIT_EXTERNAL_PIN_RESET_FLAG),
                      bm(BIT_SWR) | bm(BIT_WATCHDOG_TIMEOUT_FLAG) |
                      bm(BIT_IDLE) | bm(BIT_SLEEP));
      end
    end
    if (!master_clear_pin_n_s) begin
      state_d = ST_RESET;
    end else begin
      case (state_q)
        ST_RESET: begin
          // straps are only trusted once both sync stages hold pin values
          if (!sync_ok_q[1]) begin
            state_d = ST_RESET;
          end else if (sync2_q[5]) begin
            state_d = ST_POWER_UP_TIMER;
          end else if (can_start(clk_ok_s, sync2_q[4])) begin
            state_d  = ST_RUN;
            load_d   = 1'b1;
            target_d = VEC_RESET;
          end else begin
            state_d = ST_FROZEN;
          end
        end
        ST_POWER_UP_TIMER: begin
          if (power_up_timer_done) begin
            if (can_start(clk_ok_s, fuse_clock_fail_monitor_q)) begin
              state_d  = ST_RUN;
              load_d   = 1'b1;
              target_d = VEC_RESET;
            end else begin
              state_d = ST_FROZEN;
            end
          end
        end
        ST_FROZEN: begin
          if (clk_ok_s) begin
            state_d  = ST_RUN;
            load_d   = 1'b1;
            target_d = VEC_RESET;
          end
        end
        ST_RUN: begin
          if (wdt_ovf) begin
            cause_d = upd(cause_d, bm(BIT_WATCHDOG_TIMEOUT_FLAG),
                          bm(BIT_EXTERNAL_PIN_RESET_FLAG) | bm(BIT_SWR) |
                          bm(BIT_IDLE) | bm(BIT_SLEEP));
            state_d = ST_RESET;
          end else if (trap_reset_i) begin
            cause_d = upd(cause_d, bm(BIT_TRAP_CONFLICT_RESET_FLAG), 16'h0000);
            state_d = ST_RESET;
          end else if (illegal_op_i) begin
            cause_d = upd(cause_d, bm(BIT_ILLEGAL_OP_RESET_FLAG), 16'h0000);
            state_d = ST_RESET;
          end else if (sw_reset_i) begin
            cause_d = upd(cause_d, bm(BIT_SWR),
                          bm(BIT_EXTERNAL_PIN_RESET_FLAG) | bm(BIT_WATCHDOG_TIMEOUT_FLAG) |
                          bm(BIT_IDLE) | bm(BIT_SLEEP));
            state_d = ST_RESET;
          end else if (power_save_instr_i) begin
            state_d = power_save_instr_sleep_i ? ST_SLEEP : ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (wdt_ovf) begin
            cause_d  = upd(cause_d, bm(BIT_WATCHDOG_TIMEOUT_FLAG) | bm(BIT_IDLE),
                           16'h0000);
            state_d  = ST_RUN;
            load_d   = 1'b1;
            target_d = save_pc_q + PC_STEP;
          end else if (irq_wake_i) begin
            cause_d  = upd(cause_d, bm(BIT_IDLE), 16'h0000);
            state_d  = ST_RUN;
            load_d   = 1'b1;
            target_d = irq_vector_i;
          end
        end
        ST_SLEEP: begin
          if (wdt_ovf) begin
            cause_d  = upd(cause_d, bm(BIT_WATCHDOG_TIMEOUT_FLAG) | bm(BIT_SLEEP),
                           16'h0000);
            state_d  = ST_RUN;
            load_d   = 1'b1;
            target_d = save_pc_q + PC_STEP;
          end else if (irq_wake_i) begin
            cause_d  = upd(cause_d, bm(BIT_SLEEP), 16'h0000);
            state_d  = ST_RUN;
            load_d   = 1'b1;
            target_d = irq_vector_i;
          end
        end
        default: begin
          state_d = ST_RESET;
        end
      endcase
    end
  end

  // state, flags and pc capture
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= ST_RESET;
      cause_q <= CAUSE_POR_VAL;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      save_pc_q <= VEC_RESET;
    end else if (state_q == ST_RUN && power_save_instr_i) begin
      save_pc_q <= pc_i;
    end
  end

  // registered control outputs
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      core_reset_o    <= 1'b1;
      cpu_clk_en_o    <= 1'b0;
      periph_clk_en_o <= 1'b1;
      low_power_rc_osc_run_o      <= 1'b1;
      pc_load_o       <= 1'b0;
      pc_target_o     <= VEC_RESET;
      wdt_running_o   <= 1'b0;
    end else begin
      core_reset_o    <= (state_d == ST_RESET) || (state_d == ST_POWER_UP_TIMER) ||
                         (state_d == ST_FROZEN);
      cpu_clk_en_o    <= (state_d == ST_RUN);
      periph_clk_en_o <= (state_d != ST_SLEEP);
      low_power_rc_osc_run_o      <= wdt_en | fuse_clock_fail_monitor_q;
      pc_load_o       <= load_d;
      pc_target_o     <= target_d;
      wdt_running_o   <= wdt_en;
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (rst_i || !bus_i.rd) begin
      rdata_o <= 32'h0;
    end else begin
      case (bus_i.addr)
        REG_RESET_CAUSE: rdata_o <= {16'h0, cause_q};
        REG_PC_TARGET:   rdata_o <= {8'h0, pc_target_o};
        REG_STATE:       rdata_o <= {26'h0, state_q};
        REG_WDT_COUNT:   rdata_o <= {16'h0, wdt_cnt_q};
        default:         rdata_o <= 32'h0;
      endcase
    end
  end

endmodule

// *** include/rcw_pkg.sv ***
// rcw_pkg: constants, states and bus carrier for the reset-cause,
// watchdog and power-save block.
// assumes a 125 MHz block clock that keeps running.
package rcw_pkg;

  // register byte offsets
  localparam logic [7:0] REG_RESET_CAUSE = 8'h00;
  localparam logic [7:0] REG_PC_TARGET   = 8'h04;
  localparam logic [7:0] REG_STATE       = 8'h08;
  localparam logic [7:0] REG_WDT_COUNT   = 8'h0C;

  // reset_cause_status field positions
  localparam int BIT_TRAP_CONFLICT_RESET_FLAG  = 15;
  localparam int BIT_ILLEGAL_OP_RESET_FLAG = 14;
  localparam int BIT_EXTERNAL_PIN_RESET_FLAG   = 7;
  localparam int BIT_SWR    = 6;
  localparam int BIT_WATCHDOG_SOFT_ENABLE = 5;
  localparam int BIT_WATCHDOG_TIMEOUT_FLAG   = 4;
  localparam int BIT_SLEEP  = 3;
  localparam int BIT_IDLE   = 2;
  localparam int BIT_POR    = 0;

  localparam logic [15:0] CAUSE_POR_VAL = 16'h0001;
  localparam logic [15:0] CAUSE_WMASK   = 16'hC0FD;

  // program counter targets
  localparam logic [23:0] VEC_RESET = 24'h000000;
  localparam logic [23:0] PC_STEP   = 24'h000002;

  // timing
  localparam int CLK_KHZ = 125000;
  localparam int POWER_UP_TIMER_MS = 4;
  localparam int WDT_CNT_W = 16;
  localparam logic [15:0] WDT_TICKS = 16'h0200;

  // synchroniser reset value: {power_up_timer, clock_fail_monitor, wdt_fuse, low_power_rc_osc, clk_ok, master_clear_pin_n}
  localparam logic [5:0] SYNC_RST = 6'h01;

  typedef enum logic [5:0] {
    ST_RESET  = 6'h01,
    ST_POWER_UP_TIMER   = 6'h02,
    ST_FROZEN = 6'h04,
    ST_RUN    = 6'h08,
    ST_IDLE   = 6'h10,
    ST_SLEEP  = 6'h20
  } rcw_state_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rcw_bus_req_type;

endpackage

// *** test/rcw_core_props.sv ***
// rcw_core_props: port-level checks for the reset-cause, watchdog and power-save block.
// assumes binding onto rcw_core, one clock, synchronous active-high reset.
`timescale 1ns/100ps
module rcw_core_props
  import rcw_pkg::*;
(
  input wire logic                     mclk_i,
  input wire logic                     rst_i,
  input wire rcw_pkg::rcw_bus_req_type bus_i,
  input wire logic [31:0]              rdata_o,
  input wire logic                     power_save_instr_i,
  input wire logic                     power_save_instr_sleep_i,
  input wire logic                     irq_wake_i,
  input wire logic [23:0]              irq_vector_i,
  input wire logic                     core_reset_o,
  input wire logic                     cpu_clk_en_o,
  input wire logic                     periph_clk_en_o,
  input wire logic                     pc_load_o,
  input wire logic [23:0]              pc_target_o,
  input wire logic                     wdt_running_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  a_reset_holds: assert property (disable iff (1'b0)
    rst_i |=> core_reset_o && !cpu_clk_en_o && !pc_load_o)
    else $error("outputs not held in reset");
  a_rdata_idle: assert property (!bus_i.rd |=> rdata_o == 32'h0)
    else $error("read data outside read slot");
  a_pc_pulse: assert property (pc_load_o |=> !pc_load_o)
    else $error("pc load longer than one cycle");
  a_run_excl: assert property (cpu_clk_en_o |-> !core_reset_o && periph_clk_en_o)
    else $error("cpu clock on during reset or sleep");
  a_idle_enter: assert property (power_save_instr_i && !power_save_instr_sleep_i && cpu_clk_en_o
    |=> !cpu_clk_en_o && periph_clk_en_o)
    else $error("idle entry wrong");
  a_sleep_enter: assert property (power_save_instr_i && power_save_instr_sleep_i && cpu_clk_en_o
    && !wdt_running_o |=> !periph_clk_en_o && !cpu_clk_en_o)
    else $error("sleep entry wrong");
  a_sleep_gate: assert property (!periph_clk_en_o |-> !cpu_clk_en_o)
    else $error("cpu clock on in sleep");
  a_wake_nodelay: assert property (irq_wake_i && !cpu_clk_en_o && !core_reset_o
    |=> cpu_clk_en_o && pc_load_o && pc_target_o == $past(irq_vector_i))
    else $error("interrupt wake late or wrong vector");

  c_pc_load: cover property (pc_load_o);
  c_sleep: cover property (!periph_clk_en_o);
  c_idle_wdt: cover property (wdt_running_o && !cpu_clk_en_o && periph_clk_en_o);
endmodule

// *** test/rcw_core_bench.sv ***
// rcw_core_bench: self-checking bench for the reset-cause block.
// assumes rcw_core with a shortened power-up count; bench drives all ports.
`timescale 1ns/100ps
module rcw_core_bench;
  import rcw_pkg::*;
  logic            mclk_i, rst_i, master_clear_pin_n, clk_ok, low_power_rc_osc, low_power_rc_osc_on, software_reset_flag, trap, ill, clr;
  logic            ps, ps_sl, irq, rd_seen, core_rst, cpu_en, per_en, pc_ld, wdt_run, low_power_rc_osc_run;
  logic [23:0]     vec, pc, tgt;
  logic [31:0]     rdata;
  rcw_bus_req_type bus;
  logic [31:0]     rq[$];
  logic [23:0]     pq[$];
  int              n_mismatch, cmp_count;

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  // rc clock stands still unless enabled, phase unrelated to mclk
  initial begin
    low_power_rc_osc = 1'b0;
    forever #23 low_power_rc_osc = low_power_rc_osc_on ? ~low_power_rc_osc : 1'b0;
  end

  rcw_core #(.POWER_UP_TIMER_CYCLES(8)) rcw_core_i (.mclk_i(mclk_i), .rst_i(rst_i), .bus_i(bus),
    .rdata_o(rdata), .master_clear_pin_n_i(master_clear_pin_n), .sys_clk_ok_i(clk_ok), .low_power_rc_osc_clk_i(low_power_rc_osc),
    .wdt_fuse_en_i(1'b0), .clock_fail_monitor_en_i(1'b0), .power_up_timer_en_i(1'b0), .sw_reset_i(software_reset_flag),
    .trap_reset_i(trap), .illegal_op_i(ill), .watchdog_clear_instr_i(clr), .power_save_instr_i(ps),
    .power_save_instr_sleep_i(ps_sl), .irq_wake_i(irq), .irq_vector_i(vec), .pc_i(pc),
    .core_reset_o(core_rst), .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en),
    .low_power_rc_osc_run_o(low_power_rc_osc_run), .pc_load_o(pc_ld), .pc_target_o(tgt), .wdt_running_o(wdt_run));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, s, e);
    end
  endtask

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk_i);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    rq.push_back(e);
    @(posedge mclk_i);
    bus.rd <= 1'b0;
  endtask

  task automatic wait_cpu(input logic v, input int n);
    #1;
    for (int i = 0; i < n && cpu_en !== v; i++) begin
      @(posedge mclk_i);
      #1;
    end
    if (cpu_en !== v) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  // k: 0 software reset, 1 trap, 2 pin held low, 3 illegal op
  task automatic reset_by(input int k, input logic [31:0] e);
    pq.push_back(VEC_RESET);
    @(posedge mclk_i);
    if (k == 0) software_reset_flag <= 1'b1;
    else if (k == 1) trap <= 1'b1;
    else if (k == 3) ill <= 1'b1;
    else master_clear_pin_n <= 1'b0;
    repeat (k == 2 ? 4 : 1) @(posedge mclk_i);
    software_reset_flag <= 1'b0;
    trap <= 1'b0;
    ill <= 1'b0;
    master_clear_pin_n <= 1'b1;
    wait_cpu(1'b0, 10);
    wait_cpu(1'b1, 50);
    rd(REG_RESET_CAUSE, e);
    $display("test reset kind %0d done", k);
  endtask

  task automatic sav(input logic sl, input logic [23:0] p);
    @(posedge mclk_i);
    ps <= 1'b1;
    ps_sl <= sl;
    pc <= p;
    @(posedge mclk_i);
    ps <= 1'b0;
    wait_cpu(1'b0, 10);
  endtask

  always @(posedge mclk_i) begin
    rd_seen <= bus.rd;
    if (rd_seen === 1'b1) chk(rdata, rq.size() ? rq.pop_front() : 32'hFFFFFFFF);
    if (pc_ld === 1'b1) chk({8'h00, tgt}, {8'h00, pq.size() ? pq.pop_front() : 24'hFFFFFF});
  end

  initial begin
    logic [31:0] d;
    logic [23:0] p;
    logic [23:0] v;
    {rst_i, master_clear_pin_n, clk_ok, low_power_rc_osc_on, software_reset_flag, trap} = 6'h30;
    {ps, ps_sl, irq, ill, clr} = 5'h00;
    {vec, pc, n_mismatch, cmp_count} = '0;
    bus = '0;
    void'($urandom(32'hdd70));
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    #1;
    chk(32'(core_rst), 32'h1);
    rd(REG_STATE, 32'h00000004);
    pq.push_back(VEC_RESET);
    clk_ok <= 1'b1;
    wait_cpu(1'b1, 50);
    rd(REG_RESET_CAUSE, {16'h0000, CAUSE_POR_VAL});
    rd(REG_STATE, 32'h00000008);
    rd(8'h10, 32'h00000000);
    d = $urandom;
    wr(REG_RESET_CAUSE, d);
    rd(REG_RESET_CAUSE, {16'h0000, d[15:0] & CAUSE_WMASK});
    wr(REG_RESET_CAUSE, 32'h00000001);
    $display("test register done");
    reset_by(0, 32'h00000041);
    reset_by(1, 32'h00008041);
    reset_by(3, 32'h0000C041);
    p = 24'($urandom) & 24'hFFFFFE;
    v = 24'($urandom) & 24'hFFFFFE;
    sav(1'b0, p);
    chk(32'({cpu_en, per_en}), 32'h1);
    rd(REG_STATE, 32'h00000010);
    pq.push_back(v);
    @(posedge mclk_i);
    irq <= 1'b1;
    vec <= v;
    @(posedge mclk_i);
    irq <= 1'b0;
    wait_cpu(1'b1, 10);
    rd(REG_RESET_CAUSE, 32'h0000C045);
    wr(REG_RESET_CAUSE, 32'h00000040);
    sav(1'b1, p);
    chk(32'({cpu_en, per_en}), 32'h0);
    rd(REG_STATE, 32'h00000020);
    reset_by(2, 32'h000000C8);
    reset_by(2, 32'h00000080);
    wr(REG_RESET_CAUSE, 32'h00000020);
    low_power_rc_osc_on <= 1'b1;
    pq.push_back(p + PC_STEP);
    sav(1'b0, p);
    chk(32'({low_power_rc_osc_run, wdt_run}), 32'h3);
    wait_cpu(1'b1, 4000);
    rd(REG_RESET_CAUSE, 32'h00000034);
    pq.push_back(VEC_RESET);
    wait_cpu(1'b0, 4000);
    wait_cpu(1'b1, 50);
    rd(REG_RESET_CAUSE, 32'h00000030);
    repeat (20) @(posedge mclk_i);
    low_power_rc_osc_on <= 1'b0;
    repeat (4) @(posedge mclk_i);
    clr <= 1'b1;
    @(posedge mclk_i);
    clr <= 1'b0;
    rd(REG_WDT_COUNT, 32'h00000000);
    wr(REG_RESET_CAUSE, 32'h00000000);
    low_power_rc_osc_on <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
    chk(32'({low_power_rc_osc_run, wdt_run}), 32'h0);
    $display("test watchdog done");
    complete_run();
  end
endmodule

bind rcw_core rcw_core_props rcw_core_props_i (.mclk_i(mclk_i), .rst_i(rst_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .power_save_instr_i(power_save_instr_i), .power_save_instr_sleep_i(power_save_instr_sleep_i),
  .irq_wake_i(irq_wake_i), .irq_vector_i(irq_vector_i), .core_reset_o(core_reset_o),
  .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o), .pc_load_o(pc_load_o),
  .pc_target_o(pc_target_o), .wdt_running_o(wdt_running_o));
